// *** hdl/rcs_pkg.sv ***
/*
 * Constants shared by the reset and configuration sequencer: the register map,
 * the fields of the boot configuration word, the mode encodings and the timing counts.
 * Assumes a 20 MHz core clock.
 */
package rcs_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	// powerup delay, as a time and then as a count of cycles
	localparam int unsigned PWRUP_TIME_MS = 64;
	localparam int unsigned PWRUP_CYCLES = PWRUP_TIME_MS * (CLK_HZ / 1000);
	// brownout filter time, as a time and then as a count of cycles
	localparam int unsigned BOR_FILTER_TIME_US = 2;
	localparam int unsigned BOR_FILTER_CYCLES = (BOR_FILTER_TIME_US * (CLK_HZ / 1000000) > 1) ?
		BOR_FILTER_TIME_US * (CLK_HZ / 1000000) : 1;
	// extra wake-up settling after low-power sleep, as a time and then as a count of cycles
	localparam int unsigned LP_WAKE_TIME_US = 10;
	localparam int unsigned LP_WAKE_CYCLES = LP_WAKE_TIME_US * (CLK_HZ / 1000000);

	localparam int CFG_W = 14;
	localparam int POS_FAILSAFE = 13;
	localparam int POS_TWOSPEED = 12;
	localparam int POS_BOR_HI = 10;
	localparam int POS_BOR_LO = 9;
	localparam int POS_RSTPIN = 6;
	localparam int POS_PWRUP_N = 5;
	localparam int POS_WDT_HI = 4;
	localparam int POS_WDT_LO = 3;

	localparam logic [1:0] MODE_ON = 2'h3;
	localparam logic [1:0] MODE_NOSLEEP = 2'h2;
	localparam logic [1:0] MODE_SW = 2'h1;
	localparam logic [1:0] MODE_OFF = 2'h0;

	localparam logic [11:0] ADDR_CFG = 12'h000;
	localparam logic [11:0] ADDR_CTRL = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ = 12'h00C;
	localparam logic [11:0] ADDR_MASK = 12'h010;

	// control register bits
	localparam int CTL_BOR_SW = 0;
	localparam int CTL_WDT_SW = 1;
	localparam int CTL_LP_SLEEP = 2;
	localparam int CTL_SLEEP = 3;
	// event bits
	localparam int EV_BOR = 0;
	localparam int EV_RELEASE = 1;
	localparam int EV_READY = 2;
	localparam int EV_W = 3;

	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
endpackage : rcs_pkg

// *** hdl/hold_counter.sv ***
/*
 * Down-counter that reports done once it has counted a load value of cycles.
 * Assumes a single clock domain and an asynchronous, active-high reset.
 */
`timescale 1ns/10ps
module hold_counter #(
	parameter int unsigned WIDTH = 21
) (
	input wire logic core_clk, // clock
	input wire logic sys_rst, // async reset, high
	input wire logic start, // level: reload while high
	input wire logic [WIDTH-1:0] loadVal, // cycles to count
	output logic done // high once count expired
);
	logic [WIDTH-1:0] cnt_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= loadVal;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign done = (cnt_q == '0) && !start;
endmodule : hold_counter

// *** hdl/bor_filter.sv ***
/*
 * Filter for the low-supply indication: flags a brownout only after the
 * indication persists longer than the filter count. Assumes synchronous inputs.
 */
`timescale 1ns/10ps
module bor_filter (
	input wire logic core_clk, // clock
	input wire logic sys_rst, // async reset, high
	input wire logic armed, // detector active and ready
	input wire logic supplyLow, // raw low-supply indication
	output logic trip // level: brownout confirmed
);
	logic [7:0] cnt_q;

	// dips shorter than the filter time never trip
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
		end else if (!armed || !supplyLow) begin
			cnt_q <= 8'h00;
		end else if (cnt_q <= 8'(rcs_pkg::BOR_FILTER_CYCLES)) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	assign trip = cnt_q > 8'(rcs_pkg::BOR_FILTER_CYCLES);
endmodule : bor_filter

// *** hdl/reset_config_sequencer.sv ***
/*
 * Reset and start-up sequencer: decodes the boot configuration word, runs the
 * powerup delay timer, the brownout modes with their readiness gating, and the
 * combined internal reset; registers over AHB-Lite with an interrupt.
 * Assumes synchronous supply-monitor inputs and a power-on reset on sys_rst.
 */
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module reset_config_sequencer #(
	parameter int unsigned PWRUP_COUNT = rcs_pkg::PWRUP_CYCLES
) (
	input wire logic core_clk, // 20 MHz clock
	input wire logic sys_rst, // power-on reset, async high
	input wire logic [13:0] bootConfigurationWordOne, // configuration word
	input wire logic lowVoltageProgEnable, // programming mode strap
	input wire logic resetPin_n, // external reset pin level
	input wire logic supplyLow, // analog monitor: supply below threshold
	input wire logic detectorReady, // analog monitor: detector settled
	input wire logic wakeEvent, // wake request from sleep
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	output logic coreReset, // combined internal reset
	output logic detectorEnable, // brownout detector power
	output logic brownoutReadyFlag, // detector ready status
	output logic watchdogEnable, // watchdog run enable
	output logic resetPinEnable, // pin acts as reset
	output logic pinPullupEnable, // weak pull-up on pin
	output logic failsafeMonitorEnable, // fail-safe clock monitor
	output logic twoSpeedSwitchoverEnable, // two-speed start-up
	output logic regulatorLowPower, // regulator in low-power state
	output logic irq // level interrupt
);
	typedef enum logic [2:0] {
		ST_POR = 3'b000,
		ST_TIMER = 3'b001,
		ST_BORWAIT = 3'b011,
		ST_RUN = 3'b010,
		ST_SLEEP = 3'b110,
		ST_WAKE = 3'b111
	} seq_t;

	seq_t state_q;
	seq_t state_d;
	logic [3:0] ctrl_q;
	logic [rcs_pkg::EV_W-1:0] stat_q;
	logic [rcs_pkg::EV_W-1:0] mask_q;
	logic [1:0] borMode;
	logic [1:0] wdtMode;
	logic pwrupEnabled;
	logic inSleep;
	logic detOn;
	logic armed;
	logic borTrip;
	logic timerStart;
	logic timerDone;
	logic wakeStart;
	logic wakeDone;
	logic borGate;
	logic pinRst;
	logic aphWr_q;
	logic aphRd_q;
	logic [11:0] aphAddr_q;
	logic ready_q;
	logic [rcs_pkg::EV_W-1:0] events;

	assign borMode = bootConfigurationWordOne[rcs_pkg::POS_BOR_HI:rcs_pkg::POS_BOR_LO];
	assign wdtMode = bootConfigurationWordOne[rcs_pkg::POS_WDT_HI:rcs_pkg::POS_WDT_LO];
	assign pwrupEnabled = !bootConfigurationWordOne[rcs_pkg::POS_PWRUP_N];
	assign inSleep = (state_q == ST_SLEEP);

	// detector power per mode
	always_comb begin
		case (borMode)
			rcs_pkg::MODE_ON: detOn = 1'b1;
			rcs_pkg::MODE_NOSLEEP: detOn = !inSleep;
			rcs_pkg::MODE_SW: detOn = ctrl_q[rcs_pkg::CTL_BOR_SW];
			default: detOn = 1'b0;
		endcase
	end
	assign armed = detOn && detectorReady;

	bor_filter u_filter (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.armed(armed),
		.supplyLow(supplyLow),
		.trip(borTrip)
	);

	// mode 01 and 00 never hold start-up; forced modes wait for ready and good supply
	assign borGate = (borMode == rcs_pkg::MODE_ON || borMode == rcs_pkg::MODE_NOSLEEP) ?
		(detectorReady && !supplyLow) : 1'b1;
	assign pinRst = resetPinEnable && !resetPin_n;

	// timer reloads while any reset source is active, so it starts after all release
	assign timerStart = (state_q == ST_POR) || borTrip || pinRst;

	hold_counter #(
		.WIDTH(21)
	) u_pwrup (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(timerStart),
		.loadVal(pwrupEnabled ? 21'(PWRUP_COUNT) : 21'h00000),
		.done(timerDone)
	);

	assign wakeStart = (state_q == ST_SLEEP);

	hold_counter #(
		.WIDTH(21)
	) u_wake (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(wakeStart),
		.loadVal(ctrl_q[rcs_pkg::CTL_LP_SLEEP] ? 21'(rcs_pkg::LP_WAKE_CYCLES) : 21'h00000),
		.done(wakeDone)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_POR: state_d = ST_TIMER;
			ST_TIMER: begin
				if (timerDone) begin
					state_d = ST_BORWAIT;
				end
			end
			ST_BORWAIT: begin
				if (borGate && !pinRst) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (ctrl_q[rcs_pkg::CTL_SLEEP]) begin
					state_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wakeEvent) begin
					state_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				// only off-in-sleep mode delays wake for ready
				if (wakeDone && (borMode != rcs_pkg::MODE_NOSLEEP || detectorReady)) begin
					state_d = ST_RUN;
				end
			end
			default: state_d = ST_POR;
		endcase
		if (borTrip || pinRst) begin
			state_d = ST_TIMER;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_POR;
		end else begin
			state_q <= state_d;
		end
	end

	// internal reset held through timer and readiness wait
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			coreReset <= 1'b1;
		end else begin
			coreReset <= (state_d == ST_POR) || (state_d == ST_TIMER) || (state_d == ST_BORWAIT);
		end
	end

	// configuration decode outputs
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			detectorEnable <= 1'b0;
			brownoutReadyFlag <= 1'b0;
			watchdogEnable <= 1'b0;
			resetPinEnable <= 1'b1;
			pinPullupEnable <= 1'b1;
			failsafeMonitorEnable <= 1'b0;
			twoSpeedSwitchoverEnable <= 1'b0;
			regulatorLowPower <= 1'b0;
		end else begin
			detectorEnable <= detOn;
			brownoutReadyFlag <= armed;
			case (wdtMode)
				rcs_pkg::MODE_ON: watchdogEnable <= 1'b1;
				rcs_pkg::MODE_NOSLEEP: watchdogEnable <= !inSleep;
				rcs_pkg::MODE_SW: watchdogEnable <= ctrl_q[rcs_pkg::CTL_WDT_SW];
				default: watchdogEnable <= 1'b0;
			endcase
			// programming mode overrides the pin select
			resetPinEnable <= lowVoltageProgEnable || bootConfigurationWordOne[rcs_pkg::POS_RSTPIN];
			pinPullupEnable <= lowVoltageProgEnable || bootConfigurationWordOne[rcs_pkg::POS_RSTPIN] ||
				ctrl_q[rcs_pkg::CTL_BOR_SW + 3];
			failsafeMonitorEnable <= bootConfigurationWordOne[rcs_pkg::POS_FAILSAFE];
			twoSpeedSwitchoverEnable <= bootConfigurationWordOne[rcs_pkg::POS_TWOSPEED] ||
				bootConfigurationWordOne[rcs_pkg::POS_FAILSAFE];
			regulatorLowPower <= inSleep && ctrl_q[rcs_pkg::CTL_LP_SLEEP];
		end
	end

	// AHB-Lite slave, zero wait states
	logic accept;
	assign accept = hsel && hready && htrans[1];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aphWr_q <= 1'b0;
			aphRd_q <= 1'b0;
			aphAddr_q <= 12'h000;
		end else begin
			aphWr_q <= accept && hwrite;
			aphRd_q <= accept && !hwrite;
			aphAddr_q <= haddr[11:0];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= rcs_pkg::CTRL_RESET;
			mask_q <= rcs_pkg::MASK_RESET;
		end else begin
			if (aphWr_q && aphAddr_q == rcs_pkg::ADDR_CTRL) begin
				ctrl_q <= hwdata[3:0];
			end else if (state_q == ST_SLEEP && wakeEvent) begin
				ctrl_q[rcs_pkg::CTL_SLEEP] <= 1'b0;
			end
			if (aphWr_q && aphAddr_q == rcs_pkg::ADDR_MASK) begin
				mask_q <= hwdata[rcs_pkg::EV_W-1:0];
			end
		end
	end

	assign events[rcs_pkg::EV_BOR] = borTrip;
	assign events[rcs_pkg::EV_RELEASE] = (state_q != ST_RUN) && (state_d == ST_RUN);
	assign events[rcs_pkg::EV_READY] = armed && !brownoutReadyFlag;

	// set wins over the write-one clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_q <= '0;
		end else if (aphWr_q && aphAddr_q == rcs_pkg::ADDR_IRQ) begin
			stat_q <= (stat_q & ~hwdata[rcs_pkg::EV_W-1:0]) | events;
		end else begin
			stat_q <= stat_q | events;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_q & mask_q);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
			ready_q <= 1'b1;
		end else begin
			ready_q <= 1'b1;
			hrdata <= 32'h00000000;
			if (accept && !hwrite) begin
				case (haddr[11:0])
					rcs_pkg::ADDR_CFG: hrdata <= {18'h00000, bootConfigurationWordOne};
					rcs_pkg::ADDR_CTRL: hrdata <= {28'h0000000, ctrl_q};
					rcs_pkg::ADDR_STAT: hrdata <= {26'h000000, state_q, brownoutReadyFlag, detectorEnable,
						coreReset};
					rcs_pkg::ADDR_IRQ: hrdata <= {29'h0000000, stat_q};
					rcs_pkg::ADDR_MASK: hrdata <= {29'h0000000, mask_q};
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	assign hreadyout = ready_q;
	assign hresp = 1'b0;
endmodule : reset_config_sequencer

// *** tb/supply_monitor_model.sv ***
/* Supply monitor and reset pin model.
 Assumes the bench commands dips and pin presses. */
`timescale 1ns/10ps
module supply_monitor_model #(
	parameter int READY_DLY = 5
) (
	input wire logic core_clk, // clock
	input wire logic detectorEnable, // detector power
	input wire logic dipReq, // bench: supply low
	input wire logic pinReq, // bench: pin pressed
	output logic supplyLow, // low supply
	output logic detectorReady, // detector settled
	output logic resetPin_n // pin level
);
	int age = 0;
	always_ff @(posedge core_clk) begin
		if (!detectorEnable)
			age <= 0;
		else if (age < READY_DLY)
			age <= age + 1;
	end
	// an unpowered detector never claims ready
	assign detectorReady = detectorEnable && (age == READY_DLY);
	assign supplyLow = dipReq;
	// released pin sits at its pull-up
	assign resetPin_n = !pinReq;
endmodule : supply_monitor_model

// *** tb/reset_config_sequencer_checker.sv ***
/* Port checker for the sequencer.
 Assumes bind onto the design top. */
`timescale 1ns/10ps
module reset_config_sequencer_checker #(
	parameter int unsigned PWRUP_COUNT = 50
) (
	input wire logic core_clk, // clock
	input wire logic sys_rst, // reset
	input wire logic [13:0] bootConfigurationWordOne, // cfg
	input wire logic lowVoltageProgEnable, // strap
	input wire logic resetPin_n, // pin
	input wire logic supplyLow, // monitor
	input wire logic coreReset, // out
	input wire logic detectorEnable, // out
	input wire logic brownoutReadyFlag, // out
	input wire logic watchdogEnable, // out
	input wire logic resetPinEnable, // out
	input wire logic pinPullupEnable, // out
	input wire logic failsafeMonitorEnable, // out
	input wire logic twoSpeedSwitchoverEnable // out
);
	logic [31:0] relCnt_q;
	logic [7:0] lowRun_q;
	logic [3:0] pinAge_q;
	logic [13:0] c;
	logic ok;
	assign c = bootConfigurationWordOne;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			relCnt_q <= '0;
		else if (relCnt_q != 32'hFFFFFFFF)
			relCnt_q <= relCnt_q + 32'h1;
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst || !supplyLow)
			lowRun_q <= '0;
		else if (lowRun_q != 8'hFF)
			lowRun_q <= lowRun_q + 8'h1;
	end
	// pin age saturates so long-past presses stop counting
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			pinAge_q <= 4'hF;
		else if (!resetPin_n)
			pinAge_q <= 4'h0;
		else if (pinAge_q != 4'hF)
			pinAge_q <= pinAge_q + 4'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			ok <= 1'b0;
		else
			ok <= 1'b1;
	end
	AST_HOLD: assert property (!c[5] && relCnt_q < PWRUP_COUNT |-> coreReset)
		else $error("core left reset before the powerup delay");
	AST_FAILSAFE: assert property (ok && $stable(c) |-> failsafeMonitorEnable == c[13])
		else $error("failsafe enable wrong");
	AST_TWOSPEED: assert property (ok && $stable(c) |-> twoSpeedSwitchoverEnable == (c[12] | c[13]))
		else $error("two-speed enable wrong");
	AST_PINFUNC: assert property (ok && $stable(c) && !lowVoltageProgEnable |->
		resetPinEnable == c[6] && (!c[6] || pinPullupEnable))
		else $error("pin function wrong");
	AST_WDT: assert property (ok && $stable(c) && c[4] == c[3] |-> watchdogEnable == c[4])
		else $error("watchdog mode wrong");
	AST_DET: assert property (ok && $stable(c) && c[10] == c[9] |-> detectorEnable == c[10])
		else $error("detector mode wrong");
	AST_FILTER: assert property ($rose(coreReset) |->
		lowRun_q >= rcs_pkg::BOR_FILTER_CYCLES || pinAge_q < 4'h8)
		else $error("brownout reset on a short dip");
	AST_PINREL: assert property ($fell(coreReset) |-> !resetPinEnable || pinAge_q > 4'h2)
		else $error("release while pin held");
	AST_READY: assert property ($fell(coreReset) && c[10] |-> brownoutReadyFlag && !supplyLow)
		else $error("release before detector ready");
endmodule : reset_config_sequencer_checker
bind reset_config_sequencer reset_config_sequencer_checker #(.PWRUP_COUNT(PWRUP_COUNT)) u_chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .bootConfigurationWordOne(bootConfigurationWordOne),
	.lowVoltageProgEnable(lowVoltageProgEnable), .resetPin_n(resetPin_n), .supplyLow(supplyLow),
	.coreReset(coreReset), .detectorEnable(detectorEnable), .brownoutReadyFlag(brownoutReadyFlag),
	.watchdogEnable(watchdogEnable), .resetPinEnable(resetPinEnable), .pinPullupEnable(pinPullupEnable),
	.failsafeMonitorEnable(failsafeMonitorEnable), .twoSpeedSwitchoverEnable(twoSpeedSwitchoverEnable));

// *** tb/reset_config_sequencer_tb.sv ***
/* Bench for the sequencer: boot word table, then bus, brownout, pin and sleep cases.
 Assumes the design, the monitor model and the bound checker. */
`timescale 1ns/10ps
module reset_config_sequencer_tb;
	localparam int unsigned PW = 50;
	typedef struct packed {logic [13:0] cfg; logic [5:0] exp;} row_t;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [13:0] cfg = 14'h0;
	logic low_voltage_prog_enable = 1'b0;
	logic wake = 1'b0;
	logic dip = 1'b0;
	logic pin = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, coreReset, detEn, rdy, wdt, rpEn, puEn, fs, ts, lowPwr, irq, low, detRdy, pinN;
	int err_total = 0;
	int checked = 0;
	int cyc;
	// exp: {long start, detector, watchdog, failsafe, two-speed, reset pin}
	row_t rows[4] = '{'{14'h3FFF, 6'h1F}, '{14'h1410, 6'h3A}, '{14'h2268, 6'h07}, '{14'h0000, 6'h20}};
	initial forever #25 core_clk = ~core_clk;
	reset_config_sequencer #(.PWRUP_COUNT(PW)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.bootConfigurationWordOne(cfg), .lowVoltageProgEnable(low_voltage_prog_enable), .resetPin_n(pinN), .supplyLow(low),
		.detectorReady(detRdy), .wakeEvent(wake), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.coreReset(coreReset), .detectorEnable(detEn), .brownoutReadyFlag(rdy), .watchdogEnable(wdt),
		.resetPinEnable(rpEn), .pinPullupEnable(puEn), .failsafeMonitorEnable(fs),
		.twoSpeedSwitchoverEnable(ts), .regulatorLowPower(lowPwr), .irq(irq));
	supply_monitor_model u_mon (.core_clk(core_clk), .detectorEnable(detEn), .dipReq(dip), .pinReq(pin),
		.supplyLow(low), .detectorReady(detRdy), .resetPin_n(pinN));
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask : chk
	function automatic logic sig(input int s);
		case (s)
			0: return coreReset;
			1: return detEn;
			2: return rdy;
			3: return irq;
			default: return lowPwr;
		endcase
	endfunction : sig
	// bounded wait; cyc keeps the elapsed edges for timing checks
	task automatic waitsig(input int s, input logic v);
		cyc = 0;
		while (sig(s) !== v) begin
			@(posedge core_clk);
			cyc++;
			if (cyc > 2000) begin
				chk(32'h0, 32'h1, "timeout");
				close_out();
			end
		end
	endtask : waitsig
	task automatic hwait;
		cyc = 0;
		do begin
			@(posedge core_clk);
			cyc++;
		end while (hreadyout !== 1'b1 && cyc < 100);
		if (hreadyout !== 1'b1) begin
			chk(32'h0, 32'h1, "bus hang");
			close_out();
		end
	endtask : hwait
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= wr;
		hwait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		hwait();
		rd = hrdata;
	endtask : bus
	task automatic boot(input logic [13:0] c);
		@(posedge core_clk);
		cfg <= c;
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		waitsig(0, 1'b0);
	endtask : boot
	initial begin
		for (int i = 0; i < 4; i++) begin
			boot(rows[i].cfg);
			chk({cyc >= PW, detEn, wdt, fs, ts, rpEn}, rows[i].exp, "boot row");
			bus(1'b0, rcs_pkg::ADDR_CFG, 32'h0);
			chk(rd, {18'h0, rows[i].cfg}, "cfg read");
			$display("row %0d done", i);
		end
		boot(14'h0268);
		bus(1'b1, rcs_pkg::ADDR_CTRL, 32'h3);
		waitsig(2, 1'b1);
		chk({detEn, wdt}, 2'h3, "sw enables");
		bus(1'b0, rcs_pkg::ADDR_STAT, 32'h0);
		chk(rd[2:0], 3'h6, "status");
		bus(1'b1, rcs_pkg::ADDR_CFG, 32'h0);
		bus(1'b0, rcs_pkg::ADDR_CFG, 32'h0);
		chk(rd, 32'h268, "cfg read-only");
		bus(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h0, "unmapped");
		bus(1'b1, rcs_pkg::ADDR_CTRL, 32'hB);
		chk(detEn, 1'b1, "sw sleep");
		bus(1'b1, rcs_pkg::ADDR_CTRL, 32'h0);
		waitsig(1, 1'b0);
		$display("software modes done");
		boot(14'h3FDF);
		bus(1'b1, rcs_pkg::ADDR_IRQ, 32'h7);
		dip <= 1'b1;
		repeat (20) @(posedge core_clk);
		dip <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk(coreReset, 1'b0, "short dip");
		dip <= 1'b1;
		waitsig(0, 1'b1);
		chk(cyc >= 40, 1'b1, "filter length");
		repeat (20) @(posedge core_clk);
		dip <= 1'b0;
		waitsig(0, 1'b0);
		chk(cyc >= PW, 1'b1, "timer restart");
		bus(1'b0, rcs_pkg::ADDR_IRQ, 32'h0);
		chk({rd[0], irq}, 2'h2, "event masked");
		bus(1'b1, rcs_pkg::ADDR_MASK, 32'h1);
		waitsig(3, 1'b1);
		bus(1'b1, rcs_pkg::ADDR_IRQ, 32'h1);
		waitsig(3, 1'b0);
		chk(irq, 1'b0, "irq cleared");
		$display("brownout done");
		pin <= 1'b1;
		waitsig(0, 1'b1);
		pin <= 1'b0;
		waitsig(0, 1'b0);
		chk(cyc >= PW, 1'b1, "pin restart");
		$display("pin done");
		for (int k = 0; k < 2; k++) begin
			boot(k ? 14'h1410 : 14'h3FDF);
			bus(1'b1, rcs_pkg::ADDR_CTRL, 32'hC);
			waitsig(4, 1'b1);
			@(posedge core_clk);
			chk({detEn, wdt}, k ? 2'h0 : 2'h3, "sleep");
			// release event after wake shows when the settling delay ends
			bus(1'b1, rcs_pkg::ADDR_IRQ, 32'h7);
			bus(1'b1, rcs_pkg::ADDR_MASK, 32'h2);
			wake <= 1'b1;
			@(posedge core_clk);
			wake <= 1'b0;
			waitsig(3, 1'b1);
			chk(cyc >= rcs_pkg::LP_WAKE_CYCLES, 1'b1, "wake delay");
			waitsig(4, 1'b0);
			waitsig(1, 1'b1);
			chk(coreReset, 1'b0, "awake");
		end
		$display("sleep done");
		close_out();
	end
endmodule : reset_config_sequencer_tb
